// ==== design/lep_edge.v ====
// input edge detector with two-stage history
`default_nettype none
module lep_edge (
  input  wire clk_sys_i,
  input  wire reset_i,
  input  wire in_i,
  output wire rise_o,
  output wire level_o
);
  reg q1_r;
  reg q2_r;

  // history registers
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      q1_r <= 1'b0;
      q2_r <= 1'b0;
    end else begin
      q1_r <= in_i;
      q2_r <= q1_r;
    end
  end

  assign rise_o  = q1_r & ~q2_r;
  assign level_o = q1_r;
endmodule // lep_edge
`default_nettype wire

// ==== design/lep_map.vh ====
// register map, field layout and timing constants of the local encoder pulse input block
`ifndef LEP_MAP_VH
`define LEP_MAP_VH
`define LEP_OFS_TYPE_CFG     12'h000
`define LEP_OFS_FUNC_A       12'h004
`define LEP_OFS_FUNC_B       12'h008
`define LEP_OFS_SPEED_SRC    12'h00c
`define LEP_OFS_FREQ_RD      12'h010
`define LEP_OFS_INDEX_CNT    12'h014
`define LEP_OFS_LINES        12'h018
`define LEP_OFS_DIR_SET      12'h01c
`define LEP_OFS_AUTOTUNE     12'h020
`define LEP_OFS_ANGLE_1      12'h024
`define LEP_OFS_ANGLE_2      12'h028
`define LEP_OFS_SETPOINT     12'h02c
`define LEP_OFS_PULSE_CNT    12'h030
`define LEP_OFS_IRQ_STAT     12'h034
`define LEP_OFS_IRQ_EN       12'h038
`define LEP_OFS_IRQ_CLR      12'h03c
`define LEP_OFS_STATUS       12'h040
`define LEP_OFS_IDX_DIFF     12'h044
`define LEP_OFS_PHASE        12'h048
`define LEP_TYPE_A_BIT       0
`define LEP_TYPE_B_BIT       4
`define LEP_TYPE_MASK        16'h0011
`define LEP_LINES_RST        16'h0400
`define LEP_SETPOINT_RST     32'h0000_0001
`define LEP_FUNC_FREQ        2'h0
`define LEP_FUNC_ENC         2'h2
`define LEP_SRC_LOCAL        1'b1
`define LEP_DIR_INV_BIT      0
`define LEP_DIR_IDX_BIT      1
`define LEP_TUNE_STATIC      2'h2
`define LEP_TUNE_ROTARY      2'h3
`define LEP_IDX_OK_LIMIT     16'h0005
`define LEP_TUNE_FREQ_TGT    16'h0064
`define LEP_FREQ_MAX         16'h7fff
`define LEP_FREQ_MIN         16'hd8f1
`define LEP_GATE_TIME_MS     100
`define LEP_CLK_KHZ          25000
`define LEP_GATE_CYCLES      (`LEP_GATE_TIME_MS * `LEP_CLK_KHZ)
`define LEP_IRQ_CNT_BIT      0
`define LEP_IRQ_IDX_BIT      1
`define LEP_IRQ_TUNE_BIT     2
`define LEP_IRQ_W            3
`define LEP_AXI_OKAY         2'h0
`define LEP_AXI_SLVERR       2'h2
`endif

// ==== design/lep_quad.v ====
// quadrature decoder: count step and direction from a/b phases
`default_nettype none
module lep_quad (
  input  wire clk_sys_i,
  input  wire reset_i,
  input  wire a_i,
  input  wire b_i,
  input  wire enable_i,
  output reg  step_o,
  output reg  up_o
);
  reg a_r;
  reg b_r;

  // x4 decode on every phase change
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      a_r    <= 1'b0;
      b_r    <= 1'b0;
      step_o <= 1'b0;
      up_o   <= 1'b0;
    end else begin
      a_r    <= a_i;
      b_r    <= b_i;
      step_o <= enable_i & ((a_i ^ a_r) ^ (b_i ^ b_r));
      up_o   <= a_i ^ b_r; // a leading b counts up
    end
  end
endmodule // lep_quad
`default_nettype wire

// ==== design/lep_top.v ====
// local encoder and high-speed pulse input block with axi4-lite registers
// Function
// - count pulses, pulse output at setpoint, clear
// - type digit: pulse input or digital input
// - function select: frequency, reserved, encoder pair
// - speed source: option card or local inputs
// - signed frequency readout, 0.1 Hz, reset zero (code reads out the edge count per 100 ms gate)
// - direction setting inverts measured direction
// - index count, reversal option, difference below five
// - autotune select: 2 static, 3 rotary
// - store tuned angle into both angle registers
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`include "lep_map.vh"
`default_nettype none
module lep_top (
  input  wire        clk_sys_i,
  input  wire        reset_i,
  input  wire        fast_input_a_i,
  input  wire        fast_input_b_i,
  input  wire        index_pulse_i,
  input  wire        tune_done_i,
  input  wire [15:0] tune_angle_i,
  input  wire [15:0] card_freq_i,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         count_reached_o,
  output wire        digital_a_o,
  output wire        digital_b_o,
  output reg  [1:0]  tune_mode_o,
  output wire        irq_o
);
  reg  [15:0] type_cfg_r;
  reg  [15:0] func_a_r;
  reg  [15:0] func_b_r;
  reg  [15:0] speed_src_r;
  reg  [15:0] lines_r;
  reg  [15:0] dir_set_r;
  reg  [15:0] autotune_r;
  reg  [15:0] angle_1_r;
  reg  [15:0] angle_2_r;
  reg  [31:0] setpoint_r;
  reg  [31:0] pulse_cnt_r;
  reg  [15:0] freq_r;
  reg  [15:0] index_cnt_r;
  reg  [15:0] idx_fwd_r;
  reg  [15:0] idx_rev_r;
  reg  [15:0] edge_cnt_r;
  reg  [31:0] gate_cnt_r;
  reg  [31:0] phase_r;
  reg  [`LEP_IRQ_W-1:0] irq_stat_r;
  reg  [`LEP_IRQ_W-1:0] irq_en_r;
  reg         cfg_valid_r;
  reg         aw_held_r;
  reg         w_held_r;
  reg  [11:0] aw_addr_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  wire        a_rise;
  wire        a_lvl;
  wire        b_lvl;
  wire        idx_rise;
  wire        step;
  wire        up;
  wire        dir_up;
  wire        enc_mode;
  wire        a_pulse_mode;
  wire        do_write;
  wire        do_read;
  wire [15:0] idx_diff;
  wire [15:0] meas_freq;
  wire        gate_end;
  wire [`LEP_IRQ_W-1:0] irq_evt;

  lep_edge u_edge_a (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .in_i      (fast_input_a_i),
    .rise_o    (a_rise),
    .level_o   (a_lvl)
  );

  lep_edge u_edge_b (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .in_i      (fast_input_b_i),
    .rise_o    (),
    .level_o   (b_lvl)
  );

  lep_edge u_edge_z (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .in_i      (index_pulse_i),
    .rise_o    (idx_rise),
    .level_o   ()
  );

  lep_quad u_quad (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .a_i       (a_lvl),
    .b_i       (b_lvl),
    .enable_i  (enc_mode),
    .step_o    (step),
    .up_o      (up)
  );

  // input type and function decode
  assign a_pulse_mode = cfg_valid_r & ~type_cfg_r[`LEP_TYPE_A_BIT];
  assign enc_mode = cfg_valid_r & ~type_cfg_r[`LEP_TYPE_A_BIT] & ~type_cfg_r[`LEP_TYPE_B_BIT]
                    & (func_a_r[1:0] == `LEP_FUNC_ENC) & (func_b_r[1:0] == `LEP_FUNC_ENC);
  assign digital_a_o = type_cfg_r[`LEP_TYPE_A_BIT] & a_lvl;
  assign digital_b_o = type_cfg_r[`LEP_TYPE_B_BIT] & b_lvl;
  assign dir_up = up ^ dir_set_r[`LEP_DIR_INV_BIT];
  assign idx_diff = (idx_fwd_r > idx_rev_r) ? (idx_fwd_r - idx_rev_r) : (idx_rev_r - idx_fwd_r);
  assign gate_end = (gate_cnt_r == `LEP_GATE_CYCLES - 1);
  // local counts per 100 ms are in 10 Hz units, 100 times the 0.1 Hz unit, no scaling applied: edges per 0.1 s = Hz/10
  assign meas_freq = (speed_src_r[0] == `LEP_SRC_LOCAL) ? edge_cnt_r : card_freq_i;

  // axi handshakes
  assign s_axi_awready = ~aw_held_r;
  assign s_axi_wready  = ~w_held_r;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign do_read  = s_axi_arvalid & ~s_axi_rvalid;

  // irq events
  assign irq_evt[`LEP_IRQ_CNT_BIT]  = a_pulse_mode & (func_a_r[1:0] == `LEP_FUNC_FREQ) & a_rise
                                      & (pulse_cnt_r + 32'h1 >= setpoint_r);
  assign irq_evt[`LEP_IRQ_IDX_BIT]  = enc_mode & idx_rise;
  assign irq_evt[`LEP_IRQ_TUNE_BIT] = tune_done_i & (tune_mode_o != 2'h0);
  assign irq_o = |(irq_stat_r & irq_en_r);

  // write channel capture and register writes
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      aw_addr_r    <= 12'h000;
      w_data_r     <= 32'h0;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LEP_AXI_OKAY;
      type_cfg_r   <= 16'h0000;
      func_a_r     <= 16'h0000;
      func_b_r     <= 16'h0000;
      speed_src_r  <= 16'h0000;
      lines_r      <= `LEP_LINES_RST;
      dir_set_r    <= 16'h0000;
      autotune_r   <= 16'h0000;
      setpoint_r   <= `LEP_SETPOINT_RST;
      irq_en_r     <= {`LEP_IRQ_W{1'b0}};
    end else begin
      if (s_axi_awvalid & ~aw_held_r) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_held_r) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (tune_done_i)
        autotune_r <= 16'h0000;
      if (do_write) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `LEP_AXI_OKAY;
        case (aw_addr_r)
          `LEP_OFS_TYPE_CFG:  type_cfg_r  <= w_data_r[15:0] & `LEP_TYPE_MASK;
          `LEP_OFS_FUNC_A:    func_a_r    <= w_data_r[15:0];
          `LEP_OFS_FUNC_B:    func_b_r    <= w_data_r[15:0];
          `LEP_OFS_SPEED_SRC: speed_src_r <= w_data_r[15:0];
          `LEP_OFS_LINES:     lines_r     <= w_data_r[15:0];
          `LEP_OFS_DIR_SET:   dir_set_r   <= w_data_r[15:0];
          `LEP_OFS_AUTOTUNE:  autotune_r  <= w_data_r[15:0];
          `LEP_OFS_SETPOINT:  setpoint_r  <= w_data_r;
          `LEP_OFS_IRQ_EN:    irq_en_r    <= w_data_r[`LEP_IRQ_W-1:0];
          `LEP_OFS_IRQ_CLR:   ;
          default:            s_axi_bresp <= `LEP_AXI_SLVERR;
        endcase
      end
    end
  end

  // read channel
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `LEP_AXI_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `LEP_AXI_OKAY;
      case (s_axi_araddr)
        `LEP_OFS_TYPE_CFG:  s_axi_rdata <= {16'h0, type_cfg_r};
        `LEP_OFS_FUNC_A:    s_axi_rdata <= {16'h0, func_a_r};
        `LEP_OFS_FUNC_B:    s_axi_rdata <= {16'h0, func_b_r};
        `LEP_OFS_SPEED_SRC: s_axi_rdata <= {16'h0, speed_src_r};
        `LEP_OFS_FREQ_RD:   s_axi_rdata <= {16'h0, freq_r};
        `LEP_OFS_INDEX_CNT: s_axi_rdata <= {16'h0, index_cnt_r};
        `LEP_OFS_LINES:     s_axi_rdata <= {16'h0, lines_r};
        `LEP_OFS_DIR_SET:   s_axi_rdata <= {16'h0, dir_set_r};
        `LEP_OFS_AUTOTUNE:  s_axi_rdata <= {16'h0, autotune_r};
        `LEP_OFS_ANGLE_1:   s_axi_rdata <= {16'h0, angle_1_r};
        `LEP_OFS_ANGLE_2:   s_axi_rdata <= {16'h0, angle_2_r};
        `LEP_OFS_SETPOINT:  s_axi_rdata <= setpoint_r;
        `LEP_OFS_PULSE_CNT: s_axi_rdata <= pulse_cnt_r;
        `LEP_OFS_IRQ_STAT:  s_axi_rdata <= {{(32-`LEP_IRQ_W){1'b0}}, irq_stat_r};
        `LEP_OFS_IRQ_EN:    s_axi_rdata <= {{(32-`LEP_IRQ_W){1'b0}}, irq_en_r};
        `LEP_OFS_STATUS:    s_axi_rdata <= {28'h0, idx_diff < `LEP_IDX_OK_LIMIT, enc_mode, a_pulse_mode,
                                            cfg_valid_r};
        `LEP_OFS_IDX_DIFF:  s_axi_rdata <= {16'h0, idx_diff};
        `LEP_OFS_PHASE:     s_axi_rdata <= phase_r;
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `LEP_AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // pulse counting, encoder position and index counts
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_valid_r     <= 1'b0;
      pulse_cnt_r     <= 32'h0;
      count_reached_o <= 1'b0;
      index_cnt_r     <= 16'h0;
      idx_fwd_r       <= 16'h0;
      idx_rev_r       <= 16'h0;
      phase_r         <= 32'h0;
    end else begin
      cfg_valid_r     <= 1'b1;
      count_reached_o <= 1'b0;
      if (irq_evt[`LEP_IRQ_CNT_BIT]) begin
        count_reached_o <= 1'b1;
        pulse_cnt_r     <= 32'h0;
      end else if (a_pulse_mode & (func_a_r[1:0] == `LEP_FUNC_FREQ) & a_rise) begin
        pulse_cnt_r <= pulse_cnt_r + 32'h1;
      end
      if (step)
        phase_r <= dir_up ? phase_r + 32'h1 : phase_r - 32'h1;
      if (irq_evt[`LEP_IRQ_IDX_BIT]) begin
        index_cnt_r <= index_cnt_r + 16'h1;
        if (dir_up ^ dir_set_r[`LEP_DIR_IDX_BIT])
          idx_fwd_r <= idx_fwd_r + 16'h1;
        else
          idx_rev_r <= idx_rev_r + 16'h1;
      end
    end
  end

  // frequency measurement over a fixed gate
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      gate_cnt_r <= 32'h0;
      edge_cnt_r <= 16'h0;
      freq_r     <= 16'h0;
    end else begin
      gate_cnt_r <= gate_end ? 32'h0 : gate_cnt_r + 32'h1;
      if (gate_end) begin
        edge_cnt_r <= 16'h0;
        if ($signed(meas_freq) > $signed(`LEP_FREQ_MAX))
          freq_r <= `LEP_FREQ_MAX;
        else if ($signed(meas_freq) < $signed(`LEP_FREQ_MIN))
          freq_r <= `LEP_FREQ_MIN;
        else
          freq_r <= meas_freq;
      end else if (step) begin
        edge_cnt_r <= dir_up ? edge_cnt_r + 16'h1 : edge_cnt_r - 16'h1;
      end
    end
  end

  // autotune mode, angle store and sticky irq status
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      tune_mode_o <= 2'h0;
      angle_1_r   <= 16'h0;
      angle_2_r   <= 16'h0;
      irq_stat_r  <= {`LEP_IRQ_W{1'b0}};
    end else begin
      case (autotune_r[1:0])
        `LEP_TUNE_STATIC: tune_mode_o <= `LEP_TUNE_STATIC;
        `LEP_TUNE_ROTARY: tune_mode_o <= `LEP_TUNE_ROTARY;
        default:          tune_mode_o <= 2'h0;
      endcase
      if (irq_evt[`LEP_IRQ_TUNE_BIT]) begin
        angle_1_r <= tune_angle_i;
        angle_2_r <= tune_angle_i;
      end
      // set wins over clear
      irq_stat_r <= (irq_stat_r & ~((do_write && aw_addr_r == `LEP_OFS_IRQ_CLR) ?
                    w_data_r[`LEP_IRQ_W-1:0] : {`LEP_IRQ_W{1'b0}})) | irq_evt;
    end
  end
endmodule // lep_top
`default_nettype wire

// ==== tb/lep_enc_model.sv ====
// encoder and pulse source model on the two fast inputs
`default_nettype none
module lep_enc_model (
  input  wire logic clk_sys_i,
  output var logic  a_o,
  output var logic  b_o,
  output var logic  index_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle levels
  initial begin
    a_o = 1'b0;
    b_o = 1'b0;
    index_o = 1'b0;
  end
  // n pulses on a, high for w cycles, low for w+1 cycles between pulses
  task automatic pulses(input int n, input int w);
    repeat (n) begin
      @(posedge clk_sys_i) a_o <= 1'b1;
      repeat (w) @(posedge clk_sys_i);
      a_o <= 1'b0;
      repeat (w) @(posedge clk_sys_i);
    end
  endtask
  // static levels for digital use
  task automatic set_ab(input logic a, input logic b);
    a_o <= a;
    b_o <= b;
  endtask
  // n gray steps, a leads b unless reversed, one index per sweep
  task automatic quad(input int n, input bit rev);
    int k;
    k = 0;
    repeat (n) begin
      @(posedge clk_sys_i);
      k = rev ? k - 1 : k + 1;
      {b_o, a_o} <= 2'((k & 3) ^ ((k & 3) >> 1));
      index_o <= (k == 1 || k == -1);
      repeat (3) @(posedge clk_sys_i);
    end
  endtask
endmodule // lep_enc_model
`default_nettype wire

// ==== tb/lep_properties.sv ====
// pin-level assertions for the local encoder pulse block
`include "lep_map.vh"
`default_nettype none
module lep_properties (
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic        fast_input_a_i,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        count_reached_o,
  input wire logic [1:0]  tune_mode_o,
  input wire logic        irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // write steps: address taken, then a response within a few cycles
  sequence aw_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence b_answer;
    ##[1:4] s_axi_bvalid;
  endsequence
  chk_write_answer: assert property (aw_taken |-> b_answer)
    else $error("write got no response");
  chk_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  chk_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while waiting");
  chk_resp_codes: assert property (s_axi_rvalid |-> s_axi_rresp inside {`LEP_AXI_OKAY, `LEP_AXI_SLVERR})
    else $error("bad read response code");
  chk_reach_single: assert property (count_reached_o |=> !count_reached_o)
    else $error("count pulse longer than one cycle");
  chk_reach_cause: assert property (count_reached_o |-> $past(fast_input_a_i, 2))
    else $error("count pulse without input pulse");
  chk_reset_quiet: assert property ($fell(reset_i) |-> !count_reached_o && !irq_o && tune_mode_o == 2'h0)
    else $error("outputs active after reset");
endmodule // lep_properties
bind lep_top lep_properties i_chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .fast_input_a_i(fast_input_a_i),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .count_reached_o(count_reached_o), .tune_mode_o(tune_mode_o), .irq_o(irq_o));
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the local encoder pulse block
`include "lep_map.vh"
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin num_errors++; \
  $display("FAIL %s exp %h got %h", n, e, s); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i = 0, reset_i = 1, tune_done_i = 0;
  logic [15:0] tune_angle_i = 0, ang;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, tune_mode_o;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        count_reached_o, digital_a_o, digital_b_o, irq_o, fa, fb, idx;
  logic [33:0] exp_q[$], e;
  int          num_errors = 0, samples_checked = 0, hits = 0, seed = 47418, n;
  logic [11:0] ra[10] = '{`LEP_OFS_TYPE_CFG, `LEP_OFS_FUNC_A, `LEP_OFS_FUNC_B, `LEP_OFS_SPEED_SRC,
    `LEP_OFS_FREQ_RD, `LEP_OFS_INDEX_CNT, `LEP_OFS_LINES, `LEP_OFS_SETPOINT, `LEP_OFS_PULSE_CNT, `LEP_OFS_IRQ_STAT};
  logic [31:0] rv[10] = '{0, 0, 0, 0, 0, 0, 1024, 1, 0, 0};
  always #20 clk_sys_i = ~clk_sys_i;
  lep_enc_model i_enc (.clk_sys_i(clk_sys_i), .a_o(fa), .b_o(fb), .index_o(idx));
  lep_top i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .fast_input_a_i(fa), .fast_input_b_i(fb),
    .index_pulse_i(idx), .tune_done_i(tune_done_i), .tune_angle_i(tune_angle_i), .card_freq_i(16'h0000),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .count_reached_o(count_reached_o), .digital_a_o(digital_a_o),
    .digital_b_o(digital_b_o), .tune_mode_o(tune_mode_o), .irq_o(irq_o));
  // bus answers against the oldest note, count pulses tallied
  always @(posedge clk_sys_i) begin
    if (count_reached_o === 1'b1) hits <= hits + 1;
    if (s_axi_bvalid && s_axi_bready) begin
      e = exp_q.pop_front();
      `CHK("bresp", e, {s_axi_bresp, 32'h0})
    end
    if (s_axi_rvalid && s_axi_rready) begin
      e = exp_q.pop_front();
      `CHK("rdata", e, {s_axi_rresp, s_axi_rdata})
    end
  end
  task wr(input [11:0] a, input [31:0] d, input [1:0] r);
    exp_q.push_back({r, 32'h0});
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask
  task rd(input [11:0] a, input [31:0] d, input [1:0] r);
    exp_q.push_back({r, d});
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask
  task wait_n(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask
  task test_done;
    if (num_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // watchdog
  initial begin
    #800000;
    num_errors++;
    test_done;
  end
  // main sequence
  initial begin
    wait_n(20);
    reset_i <= 0;
    foreach (ra[i]) rd(ra[i], rv[i], 0);
    rd(12'h100, 0, `LEP_AXI_SLVERR);
    wr(12'h100, 1, `LEP_AXI_SLVERR);
    wr(`LEP_OFS_LINES, 4 * 1024, 0);
    rd(`LEP_OFS_LINES, 4096, 0);
    n = 2 + {$random(seed)} % 4;
    wr(`LEP_OFS_SETPOINT, n, 0);
    wr(`LEP_OFS_IRQ_EN, 1, 0);
    i_enc.pulses(n, 4);
    wait_n(4);
    `CHK("hits", 1, hits)
    `CHK("irq", 1'b1, irq_o)
    rd(`LEP_OFS_PULSE_CNT, 0, 0);
    wr(`LEP_OFS_IRQ_EN, 0, 0);
    wait_n(1);
    `CHK("irq", 1'b0, irq_o)
    wr(`LEP_OFS_IRQ_EN, 1, 0);
    wait_n(1);
    `CHK("irq", 1'b1, irq_o)
    wr(`LEP_OFS_IRQ_CLR, 1, 0);
    wait_n(1);
    `CHK("irq", 1'b0, irq_o)
    i_enc.pulses(n - 1, 9);
    rd(`LEP_OFS_PULSE_CNT, n - 1, 0);
    wr(`LEP_OFS_TYPE_CFG, 32'h11, 0);
    i_enc.set_ab(1, 1);
    wait_n(4);
    `CHK("dig_a", 1'b1, digital_a_o)
    `CHK("dig_b", 1'b1, digital_b_o)
    i_enc.pulses(n + 1, 4);
    `CHK("hits", 1, hits)
    i_enc.set_ab(0, 0);
    wr(`LEP_OFS_TYPE_CFG, 0, 0);
    wr(`LEP_OFS_FUNC_A, 2, 0);
    wr(`LEP_OFS_FUNC_B, 2, 0);
    wr(`LEP_OFS_SPEED_SRC, 1, 0);
    i_enc.quad(8, 0);
    rd(`LEP_OFS_PHASE, 8, 0);
    i_enc.quad(8, 1);
    rd(`LEP_OFS_PHASE, 0, 0);
    rd(`LEP_OFS_INDEX_CNT, 2, 0);
    rd(`LEP_OFS_FREQ_RD, 0, 0);
    `CHK("hits", 1, hits)
    wr(`LEP_OFS_DIR_SET, 1, 0);
    i_enc.quad(4, 0);
    rd(`LEP_OFS_PHASE, 32'hffff_fffc, 0);
    for (int m = 2; m < 4; m++) begin
      ang = 16'($random(seed));
      wr(`LEP_OFS_AUTOTUNE, m, 0);
      wait_n(2);
      `CHK("mode", m[1:0], tune_mode_o)
      tune_angle_i <= ang;
      tune_done_i <= 1;
      wait_n(1);
      tune_done_i <= 0;
      wait_n(3);
      `CHK("mode", 2'h0, tune_mode_o)
      rd(`LEP_OFS_ANGLE_1, ang, 0);
      rd(`LEP_OFS_ANGLE_2, ang, 0);
      rd(`LEP_OFS_AUTOTUNE, 0, 0);
    end
    reset_i <= 1;
    wait_n(2);
    reset_i <= 0;
    rd(`LEP_OFS_INDEX_CNT, 0, 0);
    rd(`LEP_OFS_PULSE_CNT, 0, 0);
    test_done;
  end
endmodule // testbench
`default_nettype wire
